// ==== rtl/sync_off_pin.sv ====
// Rear-panel sync-off pin controller with an AXI4-Lite register slave.
// Assumes the pin buffer resolves pin_out/pin_oe into the wire and
// returns the wire level on pin_in in the same cycle.
`timescale 1ns/1ps
`include "sync_off_params.svh"

module sync_off_pin
	import sync_off_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write channels
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read channels
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Front panel on/off requests and output state
	input wire logic panel_on,
	input wire logic panel_off,
	output logic output_on,
	// Sync pin
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe
);

	localparam pin_state_s RST = '{
		aw_rdy: 1'b1, w_rdy: 1'b1, aw_ok: 1'b0, w_ok: 1'b0,
		aw_addr: 8'h00, w_data: 32'h0000_0000, w_strb: 4'h0,
		b_valid: 1'b0, b_resp: `SO_RESP_OKAY, ar_rdy: 1'b1,
		r_valid: 1'b0, r_data: 32'h0000_0000, r_resp: `SO_RESP_OKAY,
		fn: FN_SYNC_OFF, inv: 1'b0, sel: SEL_FALSE,
		pwm_per: `SO_PWM_RST, pwm_act: `SO_PWM_RST,
		out_on: 1'b0, rmt_off: 1'b0, prev_act: 1'b0, em: EM_IDLE,
		cnt: '0, pin_out: 1'b0, pin_oe: 1'b0};

	pin_state_s s;
	pin_state_s n;
	logic pwm_level;
	logic in_act;
	logic remote_edge;
	logic wr_fire;
	logic wr_cmd;
	logic req_on;
	logic req_off;
	logic remote_hit;
	logic out_val;
	logic [31:0] ctrl_rd;
	logic [31:0] wv;

	// Merge written bytes into an old register value
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	pwm_gen u_pwm (
		.aclk(aclk),
		.aresetn(aresetn),
		.period(s.pwm_per),
		.active(s.pwm_act),
		.level(pwm_level)
	);

	// Invert picks which wire level counts as asserted on input
	assign in_act = s.inv ? pin_in : !pin_in; // [RQ7]
	// Only a fresh edge counts, so a peer pulse of any legal length
	// fires once; our own pulse is masked while we drive the wire
	assign remote_edge = in_act && !s.prev_act && !s.pin_oe; // [RQ5]
	assign remote_hit = (s.fn == FN_SYNC_OFF) && remote_edge && s.out_on;

	// Software and panel requests; off wins over a coincident on
	assign wr_fire = s.aw_ok && s.w_ok && !s.b_valid;
	assign wr_cmd = wr_fire && (s.aw_addr == `SO_ADDR_CMD) && s.w_strb[0];
	assign req_on = panel_on || (wr_cmd && s.w_data[`SO_CMD_ON_BIT]);
	assign req_off = panel_off || (wr_cmd && s.w_data[`SO_CMD_OFF_BIT]);
	assign ctrl_rd = {27'h000_0000, s.sel, s.inv, s.fn};

	// Next state of bus slave, on/off switch, pulse emitter and pin
	always_comb begin
		n = s;
		wv = merge(ctrl_rd, s.w_data, s.w_strb);
		out_val = 1'b0;
		if (awvalid && s.aw_rdy) begin
			n.aw_rdy = 1'b0;
			n.aw_ok = 1'b1;
			n.aw_addr = awaddr;
		end
		if (wvalid && s.w_rdy) begin
			n.w_rdy = 1'b0;
			n.w_ok = 1'b1;
			n.w_data = wdata;
			n.w_strb = wstrb;
		end
		if (s.b_valid && bready) begin
			n.b_valid = 1'b0;
			n.aw_rdy = 1'b1;
			n.w_rdy = 1'b1;
		end
		if (wr_fire) begin
			n.aw_ok = 1'b0;
			n.w_ok = 1'b0;
			n.b_valid = 1'b1;
			n.b_resp = `SO_RESP_OKAY;
			unique case (s.aw_addr)
				`SO_ADDR_CTRL: begin
					// Code 3 falls back to sync-off: only three functions
					unique case (wv[`SO_CTRL_FN_MSB:`SO_CTRL_FN_LSB])
						2'h1: n.fn = FN_INPUT;
						2'h2: n.fn = FN_OUTPUT;
						default: n.fn = FN_SYNC_OFF; // [RQ1]
					endcase
					n.inv = wv[`SO_CTRL_INV_BIT];
					unique case (wv[`SO_CTRL_SEL_MSB:`SO_CTRL_SEL_LSB])
						2'h1: n.sel = SEL_TRUE;
						2'h2: n.sel = SEL_PWM;
						default: n.sel = SEL_FALSE;
					endcase
				end
				`SO_ADDR_CMD: begin
				end
				`SO_ADDR_STATUS: begin
					if (s.w_strb[0] && s.w_data[`SO_ST_RMT_BIT]) begin
						n.rmt_off = 1'b0;
					end
				end
				`SO_ADDR_PWM_PER: n.pwm_per = merge(s.pwm_per, s.w_data, s.w_strb);
				`SO_ADDR_PWM_ACT: n.pwm_act = merge(s.pwm_act, s.w_data, s.w_strb);
				default: n.b_resp = `SO_RESP_SLVERR;
			endcase
		end
		if (s.r_valid && rready) begin
			n.r_valid = 1'b0;
			n.ar_rdy = 1'b1;
		end
		if (arvalid && s.ar_rdy) begin
			n.ar_rdy = 1'b0;
			n.r_valid = 1'b1;
			n.r_resp = `SO_RESP_OKAY;
			n.r_data = 32'h0000_0000;
			unique case (araddr)
				`SO_ADDR_CTRL: n.r_data = ctrl_rd;
				`SO_ADDR_CMD: n.r_data = 32'h0000_0000;
				`SO_ADDR_STATUS: begin
					n.r_data[`SO_ST_ON_BIT] = s.out_on;
					n.r_data[`SO_ST_IN_BIT] = in_act;
					n.r_data[`SO_ST_RMT_BIT] = s.rmt_off;
					n.r_data[`SO_ST_EMIT_BIT] = (s.em == EM_DRIVE);
				end
				`SO_ADDR_PWM_PER: n.r_data = s.pwm_per;
				`SO_ADDR_PWM_ACT: n.r_data = s.pwm_act;
				default: n.r_resp = `SO_RESP_SLVERR;
			endcase
		end

		// Output switch: a peer pulse only acts while we are on
		if (req_off || remote_hit) begin // [RQ4]
			n.out_on = 1'b0;
		end else if (req_on) begin // [RQ3]
			n.out_on = 1'b1;
		end
		// Sticky remote-off flag; a set in the clearing cycle wins
		if (remote_hit) begin
			n.rmt_off = 1'b1;
		end
		n.prev_act = in_act;

		// Pulse emitter, restarted by every on-to-off transition while the sync-off function stays selected
		if (s.em == EM_DRIVE) begin
			if (s.cnt == '0) begin
				n.em = EM_IDLE;
			end else begin
				n.cnt = s.cnt - 1'b1;
			end
		end
		if (s.fn == FN_SYNC_OFF && s.out_on && !n.out_on) begin // [RQ2]
			n.em = EM_DRIVE;
			n.cnt = `SO_CNT_W'(`SO_PULSE_CYC - 1);
		end
		if (n.fn != FN_SYNC_OFF) begin
			n.em = EM_IDLE;
		end

		// Pin drive; the asserted level is low unless inverted
		unique case (n.sel)
			SEL_TRUE: out_val = 1'b1;
			SEL_PWM: out_val = pwm_level; // [RQ7]
			default: out_val = 1'b0;
		endcase
		unique case (n.fn)
			FN_SYNC_OFF: begin
				n.pin_oe = (n.em == EM_DRIVE);
				n.pin_out = n.inv; // [RQ7]
			end
			FN_INPUT: begin
				n.pin_oe = 1'b0;
				n.pin_out = 1'b0;
			end
			default: begin
				n.pin_oe = 1'b1;
				n.pin_out = n.inv ? out_val : !out_val; // [RQ6]
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= RST;
		end else begin
			s <= n;
		end
	end

	// Outputs straight from the state register
	assign awready = s.aw_rdy;
	assign wready = s.w_rdy;
	assign bvalid = s.b_valid;
	assign bresp = s.b_resp;
	assign arready = s.ar_rdy;
	assign rvalid = s.r_valid;
	assign rdata = s.r_data;
	assign rresp = s.r_resp;
	assign output_on = s.out_on;
	assign pin_out = s.pin_out;
	assign pin_oe = s.pin_oe;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_sync_fall;
		s.fn == FN_SYNC_OFF && s.out_on && !n.out_on && n.fn == FN_SYNC_OFF;
	endsequence
	sequence s_true_held;
		(s.fn == FN_OUTPUT && s.sel == SEL_TRUE) [*2];
	endsequence
	sequence s_false_held;
		(s.fn == FN_OUTPUT && s.sel == SEL_FALSE) [*2];
	endsequence

	AST_FN_LEGAL: assert property ( // [RQ1]
		s.fn == FN_SYNC_OFF || s.fn == FN_INPUT || s.fn == FN_OUTPUT)
		else $error("Pin function left the three legal values");
	AST_PULSE_ON_FALL: assert property ( // [RQ2]
		s_sync_fall |=> s.pin_oe && s.pin_out == s.inv &&
		s.cnt == `SO_CNT_W'(`SO_PULSE_CYC - 1))
		else $error("No full pulse after output turned off");
	AST_PULSE_END: assert property ( // [RQ2]
		s.em == EM_DRIVE && s.cnt == '0 && !(s.out_on && !n.out_on)
		##1 s.fn == FN_SYNC_OFF |-> !s.pin_oe)
		else $error("Pulse did not end after its count");
	AST_REMOTE_IGNORED: assert property ( // [RQ3]
		s.fn == FN_SYNC_OFF && !s.out_on && remote_edge && !req_on
		|=> !s.out_on)
		else $error("Peer pulse changed an off output");
	AST_REMOTE_OFF: assert property ( // [RQ4]
		s.fn == FN_SYNC_OFF && s.out_on && remote_edge &&
		n.fn == FN_SYNC_OFF
		|=> !s.out_on ##0 s.rmt_off ##0 s.pin_oe)
		else $error("Peer pulse did not turn output off");
	AST_OUT_TRUE: assert property ( // [RQ6]
		s_true_held |-> s.pin_oe && s.pin_out == s.inv)
		else $error("True value drove wrong pin level");
	AST_OUT_FALSE: assert property ( // [RQ6]
		s_false_held |-> s.pin_oe && s.pin_out == !s.inv)
		else $error("False value drove wrong pin level");
	AST_PWM_FOLLOW: assert property ( // [RQ7]
		(s.fn == FN_OUTPUT && s.sel == SEL_PWM) [*2] |->
		s.pin_out == (s.inv ? $past(pwm_level) : !$past(pwm_level)))
		else $error("Pin does not follow PWM wave");

endmodule

// ==== rtl/sync_off_params.svh ====
// Constants for the sync-off pin controller: register map, fields, timing.
// Assumes a 50 MHz aclk; included by the package, sync_off_pin and the bench.
// Behaviour
// [RQ1] Pin takes one of three functions only
// [RQ2] Sync-off: output on-to-off transition emits pulse
// [RQ3] Sync-off: pulse while output off changes nothing
// [RQ4] Sync-off: pulse while output on turns off
// [RQ5] Peer holds its pulse active at least 30 us
// [RQ6] Output: true drives low, inverted drives high
// [RQ7] PWM square wave; invert flips input and output
`ifndef SYNC_OFF_PARAMS_SVH
`define SYNC_OFF_PARAMS_SVH

// Register byte addresses
`define SO_ADDR_CTRL 8'h00
`define SO_ADDR_CMD 8'h04
`define SO_ADDR_STATUS 8'h08
`define SO_ADDR_PWM_PER 8'h0C
`define SO_ADDR_PWM_ACT 8'h10

// Control register fields
`define SO_CTRL_FN_LSB 0
`define SO_CTRL_FN_MSB 1
`define SO_CTRL_INV_BIT 2
`define SO_CTRL_SEL_LSB 3
`define SO_CTRL_SEL_MSB 4

// Command and status bits
`define SO_CMD_ON_BIT 0
`define SO_CMD_OFF_BIT 1
`define SO_ST_ON_BIT 0
`define SO_ST_IN_BIT 1
`define SO_ST_RMT_BIT 2
`define SO_ST_EMIT_BIT 3

// Bus responses and reset values
`define SO_RESP_OKAY 2'h0
`define SO_RESP_SLVERR 2'h2
`define SO_PWM_RST 32'h0000_0000

// Pulse timing: least low time rounded up to whole cycles
`define SO_CLK_NS 20
`define SO_PULSE_NS 30000
`define SO_PULSE_CYC ((`SO_PULSE_NS + `SO_CLK_NS - 1) / `SO_CLK_NS)
`define SO_CNT_W 11

`endif

// ==== rtl/sync_off_pkg.sv ====
// Types shared by the sync-off pin controller modules.
// Assumes the constants header is on the include path.
`include "sync_off_params.svh"

package sync_off_pkg;

	typedef enum logic [1:0] {FN_SYNC_OFF, FN_INPUT, FN_OUTPUT} pin_fn_e;
	typedef enum logic [1:0] {SEL_FALSE, SEL_TRUE, SEL_PWM} out_sel_e;
	typedef enum logic {EM_IDLE, EM_DRIVE} emit_e;

	typedef struct packed {
		logic aw_rdy;
		logic w_rdy;
		logic aw_ok;
		logic w_ok;
		logic [7:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic b_valid;
		logic [1:0] b_resp;
		logic ar_rdy;
		logic r_valid;
		logic [31:0] r_data;
		logic [1:0] r_resp;
		pin_fn_e fn;
		logic inv;
		out_sel_e sel;
		logic [31:0] pwm_per;
		logic [31:0] pwm_act;
		logic out_on;
		logic rmt_off;
		logic prev_act;
		emit_e em;
		logic [`SO_CNT_W-1:0] cnt;
		logic pin_out;
		logic pin_oe;
	} pin_state_s;

	typedef struct packed {
		logic [31:0] cnt;
		logic level;
	} pwm_state_s;

endpackage

// ==== rtl/pwm_gen.sv ====
// Square wave generator: period and active time given in aclk cycles.
// Assumes both settings come from registers; a new period takes effect
// at once, so a shrinking period wraps the counter at the next cycle.
`timescale 1ns/1ps

module pwm_gen
	import sync_off_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Settings
	input wire logic [31:0] period,
	input wire logic [31:0] active,
	// Wave, high during the active part of each period
	output logic level
);

	pwm_state_s s;
	pwm_state_s n;

	// Count through the period; zero period parks the wave low
	always_comb begin
		n = s;
		if (period == 32'h0000_0000 || s.cnt >= period - 32'h0000_0001) begin
			n.cnt = 32'h0000_0000;
		end else begin
			n.cnt = s.cnt + 32'h0000_0001;
		end
		n.level = (period != 32'h0000_0000) && (n.cnt < active); // [RQ7]
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '{cnt: 32'h0000_0000, level: 1'b0};
		end else begin
			s <= n;
		end
	end

	assign level = s.level;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_PWM_ZERO_DUTY: assert property ( // [RQ7]
		(active == 32'h0000_0000) [*2] |-> !level)
		else $error("PWM wave high with zero active time");

endmodule

// ==== sim/peer_pin.sv ====
// Peer instrument model: an open-drain pull on the shared sync wire.
// Assumes the bench resolves the wire and feeds its level back on lvl.
`timescale 1ns/1ps
module peer_pin (
	// Clock
	input wire logic aclk,
	// Pulse request and its length in cycles
	input wire logic fire,
	input wire logic [15:0] len,
	// Wire level seen, own pull and last low width seen
	input wire logic lvl,
	output logic pull_low,
	output logic [15:0] low_len
);
	logic [15:0] hold = 16'h0000;
	logic [15:0] run = 16'h0000;
	initial low_len = 16'h0000;
	// Hold the pull the full requested time; a short pulse is illegal
	always @(posedge aclk) begin
		if (fire)
			hold <= len;
		else if (hold != 16'h0000)
			hold <= hold - 16'h0001;
		if (!lvl)
			run <= run + 16'h0001;
		else if (run != 16'h0000) begin
			low_len <= run;
			run <= 16'h0000;
		end
	end
	assign pull_low = hold != 16'h0000;
endmodule

// ==== sim/sync_off_pin_tb.sv ====
// Self-checking bench for the sync-off pin controller.
// Assumes the peer model and a pulled-up wire shared with the block.
`timescale 1ns/1ps
`include "sync_off_params.svh"
module sync_off_pin_tb;
	import sync_off_pkg::*;
	logic aclk = 0;
	logic aresetn = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0, k;
	logic [3:0] wstrb = 0;
	logic panel_on = 0, panel_off = 0, fire = 0;
	logic [15:0] len = 0, low_len;
	logic awready, wready, bvalid, arready, rvalid, output_on;
	logic pin_in, pin_out, pin_oe, pull_low;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [33:0] exp_q[$];
	int failures = 0, n_tests = 0, seed = 32'h6c599f7b, i;

	sync_off_pin uut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.panel_on, .panel_off, .output_on, .pin_in, .pin_out, .pin_oe);
	peer_pin peer (.aclk, .fire, .len, .lvl(pin_in), .pull_low, .low_len);

	// Wire: peer pulls low, else the block drives, else the pull-up
	assign pin_in = !pull_low & (pin_oe ? pin_out : 1'b1);

	initial forever #10 aclk = ~aclk;

	task chk(input string nm, input logic [33:0] got, input logic [33:0] e);
		n_tests++;
		if (got !== e) begin
			failures++;
			$display("unexpected %s exp %h got %h", nm, e, got);
		end
	endtask

	task results;
		if (failures == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task tick(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// Address and data offered together; each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int j = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (bvalid && bready) begin
				bready <= 0;
				chk("bresp", bresp, er);
			end
			j++;
		end while (j < 50 && (awvalid || wvalid || bready));
		if (j == 50) begin
			failures++;
			results();
		end
	endtask

	// Expected answer is queued; the monitor below compares it
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		int j = 0;
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		exp_q.push_back(e);
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
			if (rvalid) rready <= 0;
			j++;
		end while (j < 50 && (arvalid || rready));
		if (j == 50) begin
			failures++;
			results();
		end
	endtask

	// Bounded wait for the emitted pulse to end
	task wait_rel;
		for (i = 0; i < 3000 && pin_oe; i++) tick(1);
		if (i == 3000) begin
			failures++;
			results();
		end
	endtask

	// Read monitor takes the oldest note for each answer
	always @(posedge aclk) begin
		if (rvalid && rready)
			chk("rdata", {rresp, rdata}, exp_q.pop_front());
	end

	initial begin
		tick(6);
		aresetn <= 1;
		tick(1);
		rd(`SO_ADDR_CTRL, 34'h0);
		rd(`SO_ADDR_PWM_PER, 34'h0);
		rd(8'h40, {`SO_RESP_SLVERR, 32'h0000_0000});
		wr(8'h40, 32'hffff_ffff, `SO_RESP_SLVERR);
		k = $random(seed);
		wr(`SO_ADDR_PWM_ACT, k, `SO_RESP_OKAY);
		rd(`SO_ADDR_PWM_ACT, {2'h0, k});
		wr(`SO_ADDR_CTRL, 32'h0000_0003, `SO_RESP_OKAY);
		rd(`SO_ADDR_CTRL, 34'h0);
		// Local turn-off emits one pulse of exactly the least width
		wr(`SO_ADDR_CMD, 32'h0000_0001, `SO_RESP_OKAY);
		chk("on", output_on, 1);
		panel_off <= 1;
		tick(1);
		panel_off <= 0;
		tick(1);
		chk("on", output_on, 0);
		chk("oe", pin_oe, 1);
		chk("out", pin_out, 0);
		rd(`SO_ADDR_STATUS, 34'ha);
		wait_rel();
		tick(2);
		chk("width", low_len, `SO_PULSE_CYC);
		// Peer pulse while on turns the output off
		panel_on <= 1;
		tick(1);
		panel_on <= 0;
		k = $random(seed);
		fire <= 1;
		len <= 16'(`SO_PULSE_CYC) + 16'(k[5:0]);
		tick(1);
		fire <= 0;
		tick(2);
		chk("on", output_on, 0);
		wait_rel();
		tick(100);
		rd(`SO_ADDR_STATUS, 34'h4);
		wr(`SO_ADDR_STATUS, 32'h0000_0004, `SO_RESP_OKAY);
		// Peer pulse while off: no change and no own pulse
		fire <= 1;
		len <= 16'(`SO_PULSE_CYC);
		tick(1);
		fire <= 0;
		tick(1600);
		chk("on", output_on, 0);
		chk("width", low_len, `SO_PULSE_CYC);
		rd(`SO_ADDR_STATUS, 34'h0);
		// Static levels for both values and both polarities
		for (int m = 0; m < 4; m++) begin
			wr(`SO_ADDR_CTRL, {27'h0, 1'b0, m[1], m[0], 2'h2}, 2'h0);
			tick(2);
			chk("oe", pin_oe, 1);
			chk("lvl", pin_out, m[1] ? m[0] : !m[0]);
		end
		// Duty measured over whole periods, so phase does not matter
		wr(`SO_ADDR_PWM_PER, 32'h0000_000a, `SO_RESP_OKAY);
		wr(`SO_ADDR_PWM_ACT, 32'h0000_0003, `SO_RESP_OKAY);
		for (int m = 0; m < 2; m++) begin
			wr(`SO_ADDR_CTRL, {27'h0, 2'h2, m[0], 2'h2}, 2'h0);
			tick(20);
			k = 0;
			repeat (100) begin
				tick(1);
				k = k + 32'(pin_in == m[0]);
			end
			chk("duty", k, 34'd30);
		end
		// Released wire reads asserted only when inverted
		wr(`SO_ADDR_CTRL, 32'h0000_0005, `SO_RESP_OKAY);
		tick(2);
		rd(`SO_ADDR_STATUS, 34'h2);
		wr(`SO_ADDR_CTRL, 32'h0000_0001, `SO_RESP_OKAY);
		tick(2);
		chk("oe", pin_oe, 0);
		rd(`SO_ADDR_STATUS, 34'h0);
		tick(2);
		results();
	end
endmodule
